// ---- logic/rplw_pkg.sv ----
// Purpose: Shared constants, types and register map for the packet datapath
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes: Offsets are word indices on the plain register port
package rplw_pkg;
  localparam int CLK_HZ = 20000000;
  // Register offsets
  localparam logic [3:0] ADDR_LEN = 4'h0;
  localparam logic [3:0] ADDR_CFG_A = 4'h1;
  localparam logic [3:0] ADDR_CFG_B = 4'h2;
  localparam logic [3:0] ADDR_END = 4'h3;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h5;
  localparam logic [3:0] ADDR_NODE = 4'h6;
  localparam logic [3:0] ADDR_CNT = 4'h7;
  localparam logic [3:0] ADDR_CRC_LO = 4'h8;
  localparam logic [3:0] ADDR_CRC_HI = 4'h9;
  // packet_config_a fields
  localparam int CFGA_MODE_LSB = 0;
  localparam int CFGA_BITS_LSB = 2;
  localparam int CFGA_UART = 5;
  localparam int CFGA_UPOL = 6;
  // packet_config_b fields
  localparam int CFGB_WHITE = 0;
  localparam int CFGB_SWAP = 1;
  localparam int CFGB_CRC_LSB = 2;
  localparam int CFGB_RAND = 4;
  // Control bits
  localparam int CTRL_TX = 0;
  localparam int CTRL_RX = 1;
  localparam int CTRL_STOP = 2;
  // Reset values
  localparam logic [7:0] LEN_RST = 8'h00;
  localparam logic [7:0] CFGA_RST = 8'h00;
  localparam logic [7:0] CFGB_RST = 8'h00;
  localparam logic [7:0] END_RST = 8'h00;
  localparam logic [7:0] NODE_RST = 8'h00;
  localparam logic [8:0] PN9_SEED = 9'h1ff;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  // Length modes
  localparam logic [1:0] MODE_FIXED = 2'h0;
  localparam logic [1:0] MODE_INF = 2'h2;
  localparam logic [3:0] BIT_LAST = 4'h7;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA = 4'b0100,
    ST_STOP = 4'b1000
  } rplw_state_e;
  typedef struct packed {
    logic we;
    logic re;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rplw_bus_s;
endpackage

// ---- logic/rplw_pn9.sv ----
// Purpose: PN9 whitening sequence generator
// Assumes: Advanced once per whitened data bit
// Notes: Preset loads all ones at packet start
module rplw_pn9
  import rplw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic preset_i,
  input wire logic step_i,
  output logic bit_o
);
  logic [8:0] lfsr;
  logic [8:0] next_lfsr;
  // Shift toward bit 0; feedback is bit 5 xor bit 0
  always_comb begin
    next_lfsr = lfsr;
    if (preset_i) begin
      next_lfsr = PN9_SEED;
    end else if (step_i) begin
      next_lfsr = {lfsr[5] ^ lfsr[0], lfsr[8:1]};
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lfsr <= PN9_SEED;
    end else begin
      lfsr <= next_lfsr;
    end
  end
  assign bit_o = lfsr[0];
endmodule

// ---- logic/rplw_crc.sv ----
// Purpose: CRC-16 accumulator over processed data bits
// Assumes: One step per data bit, msb-first polynomial 0x8005
// Notes: Check value is shown to software, not appended here
module rplw_crc
  import rplw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic init_i,
  input wire logic step_i,
  input wire logic bit_i,
  output logic [15:0] crc_o
);
  logic [15:0] next_crc;
  // Serial update; kept simple since the long-packet path only needs continuity
  always_comb begin
    next_crc = crc_o;
    if (init_i) begin
      next_crc = CRC_SEED;
    end else if (step_i) begin
      next_crc = {crc_o[14:0], 1'b0} ^ ((crc_o[15] ^ bit_i) ? CRC_POLY : 16'h0000);
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      crc_o <= CRC_SEED;
    end else begin
      crc_o <= next_crc;
    end
  end
endmodule

// ---- logic/rplw_top.sv ----
// Purpose: Packet length control, whitening, bit reversal and async framing
// Assumes: One bit per cycle when BIT_EN_I is high; bytes ready when asked
// Notes: Registers on a plain port with read data one cycle later
module rplw_top
  import rplw_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic BIT_EN_I,
  input wire logic RX_BIT_I,
  output logic TX_BIT_O,
  output logic TX_BIT_VALID_O,
  input wire logic [7:0] TXB_DATA_I,
  output logic TXB_POP_O,
  output logic [7:0] RXB_DATA_O,
  output logic RXB_PUSH_O,
  output logic FRAME_ERR_O,
  output logic PKT_DONE_O,
  output logic [1:0] END_STATE_O
);
  rplw_bus_s bus;
  logic [7:0] packet_length_reg, packet_config_a, packet_config_b;
  logic [7:0] radio_end_config_a, node_address_reg;
  logic [7:0] next_len, next_cfga, next_cfgb, next_end, next_node;
  rplw_state_e state, next_state;
  logic is_tx, next_is_tx, busy, next_busy, ferr, next_ferr;
  logic [7:0] byte_cnt, next_byte_cnt, shreg, next_shreg;
  logic [3:0] bit_idx, next_bit_idx;
  logic tx_bit, next_tx_bit, tx_val, next_tx_val, pop, next_pop;
  logic [7:0] rxd, next_rxd;
  logic push, next_push, done, next_done, ferr_seen, next_ferr_seen;
  logic [1:0] end_st, next_end_st;
  logic [7:0] rdata, next_rdata;
  logic pn_bit, pn_preset, pn_step, crc_step, crc_bit, crc_init;
  logic [15:0] crc;
  logic [1:0] len_mode;
  logic [2:0] trail_bits;
  logic uart_en, start_val, stop_val, white_en, swap_en, rand_en, crc_on;
  logic [7:0] tx_rev, rx_rev;
  logic [3:0] bits_this_byte;
  logic last_byte, data_in, data_out, wire_bit;

  assign bus = '{we: WR_I, re: RD_I, addr: ADDR_I, wdata: WDATA_I};
  assign len_mode = packet_config_a[CFGA_MODE_LSB +: 2];
  assign trail_bits = packet_config_a[CFGA_BITS_LSB +: 3];
  assign uart_en = packet_config_a[CFGA_UART];
  assign start_val = packet_config_a[CFGA_UPOL];
  assign stop_val = ~packet_config_a[CFGA_UPOL];
  assign white_en = packet_config_b[CFGB_WHITE];
  assign swap_en = packet_config_b[CFGB_SWAP];
  assign rand_en = packet_config_b[CFGB_RAND];
  assign crc_on = (packet_config_b[CFGB_CRC_LSB +: 2] == 2'h1) ||
                  (packet_config_b[CFGB_CRC_LSB +: 2] == 2'h2);

  // Bit reversal of the byte in each direction
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rev
      assign tx_rev[g] = swap_en ? TXB_DATA_I[7 - g] : TXB_DATA_I[g];
      assign rx_rev[g] = swap_en ? next_rxd[7 - g] : next_rxd[g];
    end
  endgenerate

  // Last byte: counter plus one equals length in fixed mode; zero length means 256
  // bytes, or only trailing bits when a trailing count is set
  assign last_byte = (len_mode == MODE_FIXED) &&
                     (byte_cnt + 8'h01 == packet_length_reg ||
                      (packet_length_reg == 8'h00 && trail_bits != 3'h0 &&
                       byte_cnt == 8'h00));
  assign bits_this_byte = (last_byte && trail_bits != 3'h0) ?
                          {1'b0, trail_bits} - 4'h1 : BIT_LAST;
  // Data bit before whitening; random mode whitens constant zero
  assign data_in = rand_en ? 1'b0 : shreg[bit_idx[2:0]];
  assign data_out = white_en | rand_en ? data_in ^ pn_bit : data_in;
  assign wire_bit = white_en ? RX_BIT_I ^ pn_bit : RX_BIT_I;
  assign pn_preset = (state == ST_IDLE);
  assign pn_step = BIT_EN_I && busy && state == ST_DATA;
  assign crc_step = pn_step && crc_on;
  // Checksum clears only when a packet starts, so software can still read it afterwards
  assign crc_init = (state == ST_IDLE) && bus.we && bus.addr == ADDR_CTRL &&
                    (bus.wdata[CTRL_TX] || bus.wdata[CTRL_RX]);
  assign crc_bit = is_tx ? data_in : wire_bit;

  rplw_pn9 rplw_pn9_i (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .preset_i(pn_preset),
    .step_i(pn_step),
    .bit_o(pn_bit)
  );

  rplw_crc rplw_crc_i (
    .clk_i(CLK_SYS_I),
    .rst_n_i(RST_N_I),
    .init_i(crc_init),
    .step_i(crc_step),
    .bit_i(crc_bit),
    .crc_o(crc)
  );

  // Register writes; length, bits and mode are live during a packet
  always_comb begin
    next_len = packet_length_reg;
    next_cfga = packet_config_a;
    next_cfgb = packet_config_b;
    next_end = radio_end_config_a;
    next_node = node_address_reg;
    if (bus.we) begin
      case (bus.addr)
        ADDR_LEN: next_len = bus.wdata;
        ADDR_CFG_A: next_cfga = bus.wdata;
        ADDR_CFG_B: next_cfgb = bus.wdata;
        ADDR_END: next_end = bus.wdata;
        ADDR_NODE: next_node = bus.wdata;
        default: next_len = packet_length_reg;
      endcase
    end
    next_rdata = 8'h00;
    if (bus.re) begin
      case (bus.addr)
        ADDR_LEN: next_rdata = packet_length_reg;
        ADDR_CFG_A: next_rdata = packet_config_a;
        ADDR_CFG_B: next_rdata = packet_config_b;
        ADDR_END: next_rdata = radio_end_config_a;
        ADDR_STAT: next_rdata = {4'h0, ferr_seen, busy, is_tx, done};
        ADDR_NODE: next_rdata = node_address_reg;
        ADDR_CNT: next_rdata = byte_cnt;
        ADDR_CRC_LO: next_rdata = crc[7:0];
        ADDR_CRC_HI: next_rdata = crc[15:8];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Serial engine: start, data and stop bits per byte
  always_comb begin
    next_state = state;
    next_is_tx = is_tx;
    next_busy = busy;
    next_byte_cnt = byte_cnt;
    next_shreg = shreg;
    next_bit_idx = bit_idx;
    next_tx_bit = tx_bit;
    next_tx_val = 1'b0;
    next_pop = 1'b0;
    next_rxd = rxd;
    next_push = 1'b0;
    next_done = 1'b0;
    next_ferr = 1'b0;
    next_ferr_seen = ferr_seen;
    next_end_st = end_st;
    if (bus.we && bus.addr == ADDR_STAT) begin
      next_ferr_seen = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (bus.we && bus.addr == ADDR_CTRL &&
            (bus.wdata[CTRL_TX] || bus.wdata[CTRL_RX])) begin
          next_is_tx = bus.wdata[CTRL_TX];
          next_busy = 1'b1;
          next_byte_cnt = 8'h00;
          next_state = ST_START;
        end
      end
      ST_START: begin
        if (BIT_EN_I) begin
          next_bit_idx = 4'h0;
          next_rxd = 8'h00;
          if (is_tx) begin
            next_shreg = tx_rev;
            next_pop = 1'b1;
          end
          if (uart_en) begin
            next_state = ST_DATA;
            if (is_tx) begin
              next_tx_bit = start_val;
              next_tx_val = 1'b1;
            end else if (RX_BIT_I != start_val) begin
              next_ferr = 1'b1;
              next_ferr_seen = 1'b1;
            end
          end else begin
            next_state = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        if (BIT_EN_I) begin
          if (is_tx) begin
            next_tx_bit = data_out;
            next_tx_val = 1'b1;
          end else begin
            next_rxd[bit_idx[2:0]] = wire_bit;
          end
          next_bit_idx = bit_idx + 4'h1;
          if (bit_idx == bits_this_byte) begin
            if (!is_tx) begin
              next_push = 1'b1;
            end
            next_byte_cnt = byte_cnt + 8'h01;
            if (uart_en) begin
              next_state = ST_STOP;
            end else if (last_byte) begin
              next_state = ST_IDLE;
              next_busy = 1'b0;
              next_done = 1'b1;
              next_end_st = is_tx ? radio_end_config_a[1:0] : radio_end_config_a[3:2];
            end else begin
              next_state = ST_START;
            end
          end
        end
      end
      ST_STOP: begin
        if (BIT_EN_I) begin
          if (is_tx) begin
            next_tx_bit = stop_val;
            next_tx_val = 1'b1;
          end else if (RX_BIT_I != stop_val) begin
            next_ferr = 1'b1;
            next_ferr_seen = 1'b1;
          end
          // Counter already advanced: compare the new count against the length
          if ((len_mode == MODE_FIXED) &&
              (byte_cnt == packet_length_reg ||
               (packet_length_reg == 8'h00 && trail_bits != 3'h0 &&
                byte_cnt == 8'h01))) begin
            next_state = ST_IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_end_st = is_tx ? radio_end_config_a[1:0] : radio_end_config_a[3:2];
          end else begin
            next_state = ST_START;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Explicit stop ends any packet, the only exit in infinite mode
    if (bus.we && bus.addr == ADDR_CTRL && bus.wdata[CTRL_STOP]) begin
      next_state = ST_IDLE;
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      packet_length_reg <= LEN_RST;
      packet_config_a <= CFGA_RST;
      packet_config_b <= CFGB_RST;
      radio_end_config_a <= END_RST;
      node_address_reg <= NODE_RST;
      rdata <= 8'h00;
      state <= ST_IDLE;
      is_tx <= 1'b0;
      busy <= 1'b0;
      byte_cnt <= 8'h00;
      shreg <= 8'h00;
      bit_idx <= 4'h0;
      tx_bit <= 1'b0;
      tx_val <= 1'b0;
      pop <= 1'b0;
      rxd <= 8'h00;
      push <= 1'b0;
      done <= 1'b0;
      ferr <= 1'b0;
      ferr_seen <= 1'b0;
      end_st <= 2'h0;
      RXB_DATA_O <= 8'h00;
    end else begin
      packet_length_reg <= next_len;
      packet_config_a <= next_cfga;
      packet_config_b <= next_cfgb;
      radio_end_config_a <= next_end;
      node_address_reg <= next_node;
      rdata <= next_rdata;
      state <= next_state;
      is_tx <= next_is_tx;
      busy <= next_busy;
      byte_cnt <= next_byte_cnt;
      shreg <= next_shreg;
      bit_idx <= next_bit_idx;
      tx_bit <= next_tx_bit;
      tx_val <= next_tx_val;
      pop <= next_pop;
      rxd <= next_rxd;
      push <= next_push;
      done <= next_done;
      ferr <= next_ferr;
      ferr_seen <= next_ferr_seen;
      end_st <= next_end_st;
      if (next_push) begin
        RXB_DATA_O <= rx_rev;
      end
    end
  end

  assign RDATA_O = rdata;
  assign TX_BIT_O = tx_bit;
  assign TX_BIT_VALID_O = tx_val;
  assign TXB_POP_O = pop;
  assign RXB_PUSH_O = push;
  assign FRAME_ERR_O = ferr;
  assign PKT_DONE_O = done;
  assign END_STATE_O = end_st;

  // Counter wraps from 255 to zero on each byte
  property p_wrap;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (byte_cnt == 8'hff && next_byte_cnt != byte_cnt && state != ST_IDLE)
      |=> (byte_cnt == 8'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("byte counter did not wrap");

  // Infinite mode never raises done
  property p_inf;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (len_mode == MODE_INF) |=> !done;
  endproperty
  a_inf: assert property (p_inf) else $error("done in infinite mode");

  // Done is seen together with idle and not busy
  property p_done;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      done |-> (state == ST_IDLE && !busy);
  endproperty
  a_done: assert property (p_done) else $error("done without idle");

  // Framing error only from a framed receive start or stop slot
  property p_ferr;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      ferr |-> ($past(uart_en) && !$past(is_tx) &&
                ($past(state) == ST_START || $past(state) == ST_STOP));
  endproperty
  a_ferr: assert property (p_ferr) else $error("framing error unexpected");

  // A framed start bit carries the polarity value
  property p_start;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state == ST_START && BIT_EN_I && is_tx && uart_en)
      |=> (tx_val && tx_bit == $past(start_val));
  endproperty
  a_start: assert property (p_start) else $error("bad start bit");

  // Push happens only on receive
  property p_push;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      push |-> !is_tx;
  endproperty
  a_push: assert property (p_push) else $error("push in transmit");

  // Pop only in transmit, one per byte
  property p_pop;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      pop |-> (is_tx && !$past(pop));
  endproperty
  a_pop: assert property (p_pop) else $error("bad pop");

  // Without whitening or random mode the data bit passes untouched
  property p_plain;
    @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (state == ST_DATA && BIT_EN_I && is_tx && !white_en && !rand_en)
      |=> (tx_bit == $past(shreg[bit_idx[2:0]]));
  endproperty
  a_plain: assert property (p_plain) else $error("plain data altered");
endmodule

// ---- verification/rplw_host_model.sv ----
// Purpose: Far-side model: modem bit clock, receive bit source, transmit byte store
// Assumes: Bench loads mem and rxq directly before each packet
// Notes: Idle receive line toggles every cycle so a stale bit never looks valid
module rplw_host_model
  import rplw_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic slow_i,
  input wire logic txb_pop_i,
  output logic bit_en_o,
  output logic rx_bit_o,
  output logic [7:0] txb_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:511];
  logic rxq [$];
  int rd_ptr;
  int cnt;
  // Next byte always presented, since the engine may take it at any start slot
  assign txb_data_o = mem[rd_ptr % 512];
  // Bit slot every 2 or 4 cycles; a pop advances the store
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      bit_en_o <= 1'b0;
      rx_bit_o <= 1'b0;
      cnt <= 0;
    end else begin
      if (txb_pop_i) rd_ptr <= rd_ptr + 1;
      cnt <= (cnt >= (slow_i ? 3 : 1)) ? 0 : cnt + 1;
      bit_en_o <= en_i && (cnt == 0);
      if (en_i && cnt == 0 && rxq.size() > 0) rx_bit_o <= rxq.pop_front();
      else rx_bit_o <= ~rx_bit_o;
    end
  end
endmodule

// ---- verification/radio_packet_length_whiten_swap_tb.sv ----
// Purpose: Self-checking bench for length control, whitening, reversal, framing
// Assumes: Non-framed transmit emits only data bits, LSB first
// Notes: Expected bytes come from a bench PN9 model, never from the design
module radio_packet_length_whiten_swap_tb
  import rplw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, bit_en, rx_bit, tx_bit, tx_vld, txb_pop, rxb_push, ferr, done;
  logic en, slow;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, txb_data, rxb_data, sh;
  logic [1:0] end_st;
  logic [15:0] lfsr_st;
  logic [8:0] pn;
  logic [7:0] txq [$];
  logic [7:0] rxs [$];
  logic [7:0] d [0:3];
  int mismatches, check_count, pops, dones, ferrs, nb;
  rplw_top rplw_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BIT_EN_I(bit_en), .RX_BIT_I(rx_bit),
    .TX_BIT_O(tx_bit), .TX_BIT_VALID_O(tx_vld), .TXB_DATA_I(txb_data), .TXB_POP_O(txb_pop),
    .RXB_DATA_O(rxb_data), .RXB_PUSH_O(rxb_push), .FRAME_ERR_O(ferr), .PKT_DONE_O(done),
    .END_STATE_O(end_st));
  rplw_host_model rplw_host_model_i (.clk_i(clk), .rst_n_i(rst_n), .en_i(en), .slow_i(slow),
    .txb_pop_i(txb_pop), .bit_en_o(bit_en), .rx_bit_o(rx_bit), .txb_data_o(txb_data));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Event monitor; bits assembled LSB first into bytes
  always @(posedge clk) begin
    if (tx_vld === 1'b1) begin
      sh = {tx_bit, sh[7:1]};
      nb++;
      if (nb == 8) begin
        txq.push_back(sh);
        nb = 0;
      end
    end
    if (rxb_push === 1'b1) rxs.push_back(rxb_data);
    if (ferr === 1'b1) ferrs++;
    if (done === 1'b1) dones++;
    if (txb_pop === 1'b1) pops++;
  end
  function automatic logic [7:0] rnd();
    lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
    return lfsr_st[7:0];
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction
  // Whitening byte for the next eight bits, then advance the bench PN9
  function automatic logic [7:0] pn_next();
    pn_next = pn[7:0];
    repeat (8) pn = {pn[5] ^ pn[0], pn[8:1]};
  endfunction
  // Checksum over one byte, bit 0 first, as the engine steps it
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] v);
    crc8 = c;
    for (int j = 0; j < 8; j++) crc8 = {crc8[14:0], 1'b0} ^ ((crc8[15] ^ v[j]) ? CRC_POLY : 16'h0000);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(16'(rdata), 16'(exp));
  endtask
  task automatic setup(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ln);
    wr_reg(ADDR_LEN, ln);
    wr_reg(ADDR_CFG_A, ca);
    wr_reg(ADDR_CFG_B, cb);
    txq.delete();
    rxs.delete();
    nb = 0;
    pops = 0;
    dones = 0;
    ferrs = 0;
    pn = PN9_SEED;
    rplw_host_model_i.rd_ptr = 0;
  endtask
  task automatic wait_pops(input int n);
    for (int k = 0; k < 20000 && pops < n; k++) @(posedge clk);
  endtask
  // Bounded wait for the end pulse, then stop the bit clock
  task automatic wait_done(input int limit);
    for (int k = 0; k < limit && dones == 0; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    en <= 1'b0;
    chk(16'(dones), 16'h0001);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Watchdog sized well above the roughly 10k cycles the run needs
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] b, w, cb;
    logic [15:0] ce;
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    en = 1'b0;
    slow = 1'b0;
    lfsr_st = 16'h53cd;
    mismatches = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Register reset values, readback, unmapped place
    rd_reg(ADDR_LEN, LEN_RST);
    rd_reg(ADDR_CFG_A, CFGA_RST);
    rd_reg(ADDR_CFG_B, CFGB_RST);
    rd_reg(ADDR_END, END_RST);
    rd_reg(ADDR_NODE, NODE_RST);
    b = rnd();
    wr_reg(ADDR_NODE, rev8(b));
    rd_reg(ADDR_NODE, rev8(b));
    wr_reg(4'hf, 8'h5a);
    rd_reg(4'hf, 8'h00);
    wr_reg(ADDR_END, 8'h09);
    rd_reg(ADDR_END, 8'h09);
    // Transmit table: whitening, reversal, random data, both with slow bit clock
    for (int c = 0; c < 4; c++) begin
      cb = (c == 0) ? 8'h01 : (c == 1) ? 8'h02 : (c == 2) ? 8'h10 : 8'h07;
      slow <= (c == 3);
      setup(8'h00, cb, 8'h04);
      for (int i = 0; i < 4; i++) begin
        d[i] = (c == 0) ? {8'hab, 8'h80, 8'hff, 8'h00} >> (8 * (3 - i)) :
               (c == 1) ? {8'h03, 8'h57, 8'h26, 8'hb2} >> (8 * (3 - i)) : rnd();
        rplw_host_model_i.mem[i] = d[i];
      end
      wr_reg(ADDR_CTRL, 8'h01);
      en <= 1'b1;
      wait_done(2000);
      chk(16'(end_st), 16'h0001);
      chk(16'(txq.size()), 16'h0004);
      ce = CRC_SEED;
      for (int i = 0; i < 4 && i < txq.size(); i++) begin
        b = cb[CFGB_SWAP] ? rev8(d[i]) : d[i];
        if (cb[CFGB_CRC_LSB +: 2] == 2'h1) ce = crc8(ce, b);
        w = pn_next();
        b = cb[CFGB_RAND] ? w : (cb[CFGB_WHITE] ? b ^ w : b);
        chk(16'(txq[i]), 16'(b));
      end
      // Checksum runs on reversed, unwhitened data and is held after the packet
      rd_reg(ADDR_CRC_LO, ce[7:0]);
      rd_reg(ADDR_CRC_HI, ce[15:8]);
    end
    slow <= 1'b0;
    // Length shortened mid-packet once the host has seen two bytes
    setup(8'h00, 8'h00, 8'hc8);
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_pops(2);
    wr_reg(ADDR_LEN, 8'h04);
    wait_done(2000);
    chk(16'(pops), 16'h0004);
    // Long packet: infinite mode with length mod 256, then fixed for the tail
    setup({6'h00, MODE_INF}, 8'h00, 8'h02);
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_pops(200);
    chk(16'(dones), 16'h0000);
    wr_reg(ADDR_CFG_A, {6'h00, MODE_FIXED});
    wait_done(6000);
    chk(16'(pops), 16'h0102);
    // Zero length with zero trailing bits
    setup(8'h00, 8'h00, 8'h00);
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_done(8000);
    chk(16'(pops), 16'h0100);
    // Trailing bits only: zero length with a three-bit count
    setup(8'h0c, 8'h00, 8'h00);
    rplw_host_model_i.mem[0] = 8'h05;
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_done(200);
    chk(16'(pops), 16'h0001);
    chk(16'(nb), 16'h0003);
    chk(16'(sh[7:5]), 16'h0005);
    // Framed whitened transmit, inverted polarity; framing bits stay unwhitened
    setup(8'h60, 8'h01, 8'h02);
    rplw_host_model_i.mem[0] = 8'h00;
    rplw_host_model_i.mem[1] = 8'hff;
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_done(2000);
    chk(16'(txq.size()), 16'h0002);
    chk(16'(nb), 16'h0004);
    chk(16'(txq[0]), 16'h00ff);
    chk(16'(txq[1]), 16'h00f5);
    // Stop strobe is the only way out of infinite mode
    setup({6'h00, MODE_INF}, 8'h00, 8'h00);
    wr_reg(ADDR_CTRL, 8'h01);
    en <= 1'b1;
    wait_pops(3);
    wr_reg(ADDR_CTRL, 8'h04);
    en <= 1'b0;
    rd_reg(ADDR_STAT, 8'h02);
    chk(16'(dones), 16'h0000);
    // Framed receive, whitened and reversed, both polarities; bad stop bit first pass
    for (int p = 0; p < 2; p++) begin
      setup(8'h20 | (8'(p) << CFGA_UPOL), 8'h03, 8'h03);
      for (int i = 0; i < 3; i++) begin
        d[i] = rnd();
        b = d[i] ^ pn_next();
        rplw_host_model_i.rxq.push_back(p[0]);
        for (int j = 0; j < 8; j++) rplw_host_model_i.rxq.push_back(b[j]);
        rplw_host_model_i.rxq.push_back(~p[0] ^ (p == 0 && i == 1));
      end
      pn = PN9_SEED;
      wr_reg(ADDR_CTRL, 8'h02);
      en <= 1'b1;
      wait_done(2000);
      chk(16'(end_st), 16'h0002);
      chk(16'(ferrs), (p == 0) ? 16'h0001 : 16'h0000);
      chk(16'(rxs.size()), 16'h0003);
      for (int i = 0; i < 3 && i < rxs.size(); i++) chk(16'(rxs[i]), 16'(rev8(d[i])));
    end
    // Sticky framing flag survives the packet; writing status clears it
    rd_reg(ADDR_STAT, 8'h08);
    wr_reg(ADDR_STAT, 8'h00);
    rd_reg(ADDR_STAT, 8'h00);
    tally_and_finish();
  end
endmodule
